// file: hw/apiu_defines.svh
`ifndef APIU_DEFINES_SVH
`define APIU_DEFINES_SVH

// source indices and counts
`define APIU_NSRC 6
`define APIU_NLIM 5
`define APIU_SRC_MASS 0
`define APIU_SRC_DENS 1
`define APIU_SRC_VOL 2
`define APIU_SRC_TEMP 3
`define APIU_SRC_SLUG 4
`define APIU_SRC_DIAG 5

// severity codes
`define APIU_SEV_OFF 2'h0
`define APIU_SEV_WARN 2'h1
`define APIU_SEV_ALARM 2'h2

// register byte offsets, per-source blocks step by one word
`define APIU_OFF_CFG 8'h00
`define APIU_OFF_LIM 8'h20
`define APIU_OFF_STATUS 8'h40
`define APIU_OFF_IRQ_STAT 8'h44
`define APIU_OFF_IRQ_MASK 8'h48
`define APIU_OFF_LATCH_CLR 8'h4C
`define APIU_OFF_TRIM 8'h50
`define APIU_OFF_READBACK 8'h54

// trim register fields
`define APIU_TRIM_START 0
`define APIU_TRIM_SEL 1
`define APIU_TRIM_CONFIRM 2
`define APIU_TRIM_DECLINE 3
`define APIU_TRIM_ACCEPT 4
`define APIU_TRIM_VAL_LSB 16

// flash timing
`define APIU_CLK_MHZ 100
`define APIU_FLASH_HALF_MS 250
`define APIU_FLASH_HALF_CYC (`APIU_FLASH_HALF_MS * 1000 * `APIU_CLK_MHZ)
`define APIU_FLASH_GAP_HALVES 4
`endif

// file: hw/apiu_pkg.sv
`include "apiu_defines.svh"
package apiu_pkg;
   // per-source configuration word, low half of the register
   typedef struct packed {
      logic [7:0] delay;
      logic [3:0] code;
      logic latch;
      logic contact;
      logic [1:0] sev;
   } apiu_cfg_t;

   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
   } apiu_lim_t;

   typedef enum logic [1:0] {
      APIU_TR_IDLE = 2'b00,
      APIU_TR_ASK = 2'b01,
      APIU_TR_FIXED = 2'b10
   } apiu_trim_t;

   typedef enum logic [1:0] {
      APIU_FL_IDLE = 2'b00,
      APIU_FL_ON = 2'b01,
      APIU_FL_OFF = 2'b10,
      APIU_FL_GAP = 2'b11
   } apiu_flash_st_t;

   typedef struct packed {
      apiu_flash_st_t st;
      logic [31:0] cnt;
      logic [3:0] left;
      logic red;
      logic green;
      logic led_red;
      logic led_green;
   } apiu_flash_state_t;
endpackage : apiu_pkg

// file: hw/apiu_flash_if.sv
`timescale 1ns/1ps
interface apiu_flash_if;
   logic req_valid;
   logic [1:0] sev;
   logic [3:0] code;
   logic busy;
   logic led_red;
   logic led_green;
   modport ctrl (output req_valid, sev, code,
                 input busy, led_red, led_green);
   modport flash (input req_valid, sev, code,
                  output busy, led_red, led_green);
endinterface : apiu_flash_if

// file: hw/apiu_flasher.sv
`timescale 1ns/1ps
`include "apiu_defines.svh"
module apiu_flasher #(
   parameter int unsigned HALF_CYC = `APIU_FLASH_HALF_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request and led
   apiu_flash_if.flash fl
);
   localparam logic [31:0] HALF_END = 32'(HALF_CYC - 1);
   localparam logic [31:0] GAP_END =
      32'(HALF_CYC * `APIU_FLASH_GAP_HALVES - 1);

   apiu_pkg::apiu_flash_state_t s_reg, s_next;

   // code and colour are sampled only when idle, so a sequence in
   // progress always finishes with the pattern it began with
   always_comb
   begin
      s_next = s_reg;
      s_next.cnt = s_reg.cnt + 32'h0000_0001;
      unique case (s_reg.st)
         apiu_pkg::APIU_FL_IDLE:
         begin
            s_next.cnt = 32'h0000_0000;
            if (fl.req_valid)
            begin
               s_next.left = (fl.code == 4'h0) ? 4'h1 : fl.code;
               s_next.red = (fl.sev == `APIU_SEV_ALARM);
               s_next.green = (fl.sev == `APIU_SEV_WARN);
               s_next.led_red = (fl.sev == `APIU_SEV_ALARM);
               s_next.led_green = (fl.sev == `APIU_SEV_WARN);
               s_next.st = apiu_pkg::APIU_FL_ON;
            end
         end
         apiu_pkg::APIU_FL_ON:
            if (s_reg.cnt == HALF_END)
            begin
               s_next.cnt = 32'h0000_0000;
               s_next.left = s_reg.left - 4'h1;
               s_next.led_red = 1'b0;
               s_next.led_green = 1'b0;
               s_next.st = apiu_pkg::APIU_FL_OFF;
            end
         apiu_pkg::APIU_FL_OFF:
            if (s_reg.cnt == HALF_END)
            begin
               s_next.cnt = 32'h0000_0000;
               if (s_reg.left == 4'h0)
                  s_next.st = apiu_pkg::APIU_FL_GAP;
               else
               begin
                  s_next.led_red = s_reg.red;
                  s_next.led_green = s_reg.green;
                  s_next.st = apiu_pkg::APIU_FL_ON;
               end
            end
         apiu_pkg::APIU_FL_GAP:
            if (s_reg.cnt == GAP_END)
               s_next.st = apiu_pkg::APIU_FL_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         s_reg <= '0;
      else
         s_reg <= s_next;

   assign fl.busy = (s_reg.st != apiu_pkg::APIU_FL_IDLE);
   assign fl.led_red = s_reg.led_red;
   assign fl.led_green = s_reg.led_green;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_colour_hold;
      fl.busy && $past(fl.busy) |-> $stable(s_reg.red) && $stable(s_reg.green);
   endproperty
   a_colour_hold: assert property (p_colour_hold)
      else $error("flash colour changed inside a sequence");

   property p_never_both;
      !(fl.led_red && fl.led_green);
   endproperty
   a_never_both: assert property (p_never_both)
      else $error("led lit red and green together");

   c_red_flash: cover property (fl.led_red);
   c_green_flash: cover property (fl.led_green);
endmodule : apiu_flasher

// file: hw/apiu_alarm.sv
`timescale 1ns/1ps
`include "apiu_defines.svh"
module apiu_alarm #(
   parameter int unsigned FLASH_HALF_CYC = `APIU_FLASH_HALF_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // process values and device state
   input wire logic [15:0] pv_mass_flow,
   input wire logic [15:0] pv_density,
   input wire logic [15:0] pv_vol_flow,
   input wire logic [15:0] pv_temperature,
   input wire logic diag_fail,
   input wire logic sec_tick,
   input wire logic [15:0] primary_output_current,
   // indication and reporting
   output logic led_red,
   output logic led_green,
   output logic alarm_contact,
   output logic alarm_to_outputs,
   output logic [5:0] host_alarm,
   output logic irq,
   // analog output trim
   output logic fixed_mode_primary,
   output logic fixed_mode_secondary,
   output logic [15:0] fixed_value
);
   typedef struct packed {
      apiu_pkg::apiu_cfg_t [`APIU_NSRC-1:0] cfg;
      apiu_pkg::apiu_lim_t [`APIU_NLIM-1:0] lim;
      logic [`APIU_NLIM-1:0][7:0] dcnt;
      logic [`APIU_NSRC-1:0] latched;
      logic [`APIU_NSRC-1:0] ind;
      logic [`APIU_NSRC-1:0] irq_stat;
      logic [`APIU_NSRC-1:0] irq_mask;
      logic [`APIU_NSRC-1:0] host;
      apiu_pkg::apiu_trim_t trim;
      logic trim_sel;
      logic fixed_pri;
      logic fixed_sec;
      logic [15:0] fixed_val;
      logic [15:0] readback;
      logic [31:0] prdata;
      logic contact_closed;
      logic alarm_out;
      logic [1:0] sel_sev;
      logic [3:0] sel_code;
   } apiu_state_t;

   apiu_state_t s_reg, s_next;
   apiu_flash_if fl ();

   // per-source word decode: valid bit and index within a block
   function automatic logic [3:0] apiu_src_idx(input logic [7:0] a,
                                                input logic [7:0] base,
                                                input int unsigned n);
      logic [7:0] d;
      d = a - base;
      apiu_src_idx = 4'h0;
      if (a >= base && d[1:0] == 2'h0 && d[7:2] < 6'(n))
         apiu_src_idx = {1'b1, d[4:2]};
   endfunction : apiu_src_idx

   function automatic logic apiu_mapped(input logic [7:0] a);
      logic [3:0] c;
      logic [3:0] l;
      c = apiu_src_idx(a, `APIU_OFF_CFG, `APIU_NSRC);
      l = apiu_src_idx(a, `APIU_OFF_LIM, `APIU_NLIM);
      apiu_mapped = c[3] || l[3] ||
         a == `APIU_OFF_STATUS || a == `APIU_OFF_IRQ_STAT ||
         a == `APIU_OFF_IRQ_MASK || a == `APIU_OFF_LATCH_CLR ||
         a == `APIU_OFF_TRIM || a == `APIU_OFF_READBACK;
   endfunction : apiu_mapped

   logic wr;
   logic rd_setup;
   logic [3:0] cfg_hit;
   logic [3:0] lim_hit;
   logic [`APIU_NLIM-1:0][15:0] pv;
   logic [`APIU_NSRC-1:0] en;
   logic [`APIU_NSRC-1:0] raw;
   logic [`APIU_NSRC-1:0] clr;
   logic [`APIU_NSRC-1:0] w1c;
   logic [`APIU_NSRC-1:0] sev2;
   logic [`APIU_NSRC-1:0] cmask;
   logic [5:0] best;

   // zero wait state slave; errors only on unmapped words
   assign pready = 1'b1;
   assign pslverr = psel && penable && !apiu_mapped(paddr);
   assign wr = psel && penable && pwrite && apiu_mapped(paddr);
   assign rd_setup = psel && !penable && !pwrite;
   assign cfg_hit = apiu_src_idx(paddr, `APIU_OFF_CFG, `APIU_NSRC);
   assign lim_hit = apiu_src_idx(paddr, `APIU_OFF_LIM, `APIU_NLIM);
   assign clr = (wr && paddr == `APIU_OFF_LATCH_CLR) ?
                pwdata[`APIU_NSRC-1:0] : '0;
   assign w1c = (wr && paddr == `APIU_OFF_IRQ_STAT) ?
                pwdata[`APIU_NSRC-1:0] : '0;

   // slug source watches density again, against its own limits
   assign pv[`APIU_SRC_MASS] = pv_mass_flow;
   assign pv[`APIU_SRC_DENS] = pv_density;
   assign pv[`APIU_SRC_VOL] = pv_vol_flow;
   assign pv[`APIU_SRC_TEMP] = pv_temperature;
   assign pv[`APIU_SRC_SLUG] = pv_density;

   // limit sources: delay counted in whole seconds of sec_tick
   genvar g;
   generate
      for (g = 0; g < `APIU_NLIM; g++)
      begin : g_lim
         logic oor;
         assign oor = pv[g] > s_reg.lim[g].hi || pv[g] < s_reg.lim[g].lo;
         assign raw[g] = en[g] && oor &&
                         s_reg.dcnt[g] >= s_reg.cfg[g].delay;
      end
      for (g = 0; g < `APIU_NSRC; g++)
      begin : g_en
         assign en[g] = s_reg.cfg[g].sev != `APIU_SEV_OFF;
         assign sev2[g] = s_reg.cfg[g].sev == `APIU_SEV_ALARM;
         assign cmask[g] = s_reg.cfg[g].contact;
      end
   endgenerate
   // state source: diagnostic failure has no limits or delay
   assign raw[`APIU_SRC_DIAG] = en[`APIU_SRC_DIAG] && diag_fail;

   // all state updates in one place
   always_comb
   begin
      logic [5:0] rank;
      rank = 6'h00;
      best = 6'h00;
      s_next = s_reg;
      // delay counters restart whenever the value is back in range
      for (int i = 0; i < `APIU_NLIM; i++)
         if (!g_lim_oor(i) || !en[i])
            s_next.dcnt[i] = 8'h00;
         else if (sec_tick && s_reg.dcnt[i] < s_reg.cfg[i].delay)
            s_next.dcnt[i] = s_reg.dcnt[i] + 8'h01;
      // set beats clear, so a still-present condition relatches
      s_next.latched = ((s_reg.latched & ~clr) |
         (raw & latch_mask())) & en;
      s_next.ind = (s_next.latched | raw) & en;
      s_next.irq_stat = (s_reg.irq_stat & ~w1c) |
                        (s_next.ind & ~s_reg.ind);
      s_next.host = s_next.ind;
      // pick highest severity, ties go to the larger code; equal
      // codes are allowed and the lower index then wins
      for (int i = 0; i < `APIU_NSRC; i++)
      begin
         rank = {s_reg.cfg[i].sev, s_reg.cfg[i].code};
         if (s_next.ind[i] && rank > best)
            best = rank;
      end
      s_next.sel_sev = best[5:4];
      s_next.sel_code = best[3:0];
      s_next.alarm_out = |(s_next.ind & sev2);
      s_next.contact_closed = |(s_next.ind & contact_mask());
      s_next.readback = primary_output_current;
      // register writes
      if (wr && cfg_hit[3])
         s_next.cfg[cfg_hit[2:0]] = pwdata[15:0];
      if (wr && lim_hit[3])
         s_next.lim[lim_hit[2:0]] = pwdata;
      if (wr && paddr == `APIU_OFF_IRQ_MASK)
         s_next.irq_mask = pwdata[`APIU_NSRC-1:0];
      // trim sequence: ask, then fixed until the operator accepts
      unique case (s_reg.trim)
         apiu_pkg::APIU_TR_IDLE:
            if (wr && paddr == `APIU_OFF_TRIM && pwdata[`APIU_TRIM_START])
            begin
               s_next.trim = apiu_pkg::APIU_TR_ASK;
               s_next.trim_sel = pwdata[`APIU_TRIM_SEL];
               s_next.fixed_val = pwdata[`APIU_TRIM_VAL_LSB +: 16];
            end
         apiu_pkg::APIU_TR_ASK:
            if (wr && paddr == `APIU_OFF_TRIM)
            begin
               if (pwdata[`APIU_TRIM_DECLINE])
                  s_next.trim = apiu_pkg::APIU_TR_IDLE;
               else if (pwdata[`APIU_TRIM_CONFIRM])
               begin
                  s_next.trim = apiu_pkg::APIU_TR_FIXED;
                  s_next.fixed_pri = !s_reg.trim_sel;
                  s_next.fixed_sec = s_reg.trim_sel;
               end
            end
         apiu_pkg::APIU_TR_FIXED:
            if (wr && paddr == `APIU_OFF_TRIM)
            begin
               // every write here rewrites the value, the accepting write included
               s_next.fixed_val = pwdata[`APIU_TRIM_VAL_LSB +: 16];
               if (pwdata[`APIU_TRIM_ACCEPT])
               begin
                  s_next.trim = apiu_pkg::APIU_TR_IDLE;
                  s_next.fixed_pri = 1'b0;
                  s_next.fixed_sec = 1'b0;
               end
            end
         default:
            s_next.trim = apiu_pkg::APIU_TR_IDLE;
      endcase
      // read data is captured in the setup phase for the access phase
      if (rd_setup)
      begin
         s_next.prdata = 32'h0000_0000;
         if (cfg_hit[3])
            s_next.prdata[15:0] = s_reg.cfg[cfg_hit[2:0]];
         else if (lim_hit[3])
            s_next.prdata = s_reg.lim[lim_hit[2:0]];
         else
            unique case (paddr)
               `APIU_OFF_STATUS:
                  s_next.prdata[19:0] = {s_reg.contact_closed,
                     s_reg.alarm_out, s_reg.sel_code, s_reg.sel_sev,
                     s_reg.latched, s_reg.ind};
               `APIU_OFF_IRQ_STAT:
                  s_next.prdata[5:0] = s_reg.irq_stat;
               `APIU_OFF_IRQ_MASK:
                  s_next.prdata[5:0] = s_reg.irq_mask;
               `APIU_OFF_TRIM:
                  s_next.prdata = {s_reg.fixed_val, 12'h000,
                     s_reg.trim_sel, 1'b0, s_reg.trim};
               `APIU_OFF_READBACK:
                  s_next.prdata[15:0] = s_reg.readback;
               default:
                  s_next.prdata = 32'h0000_0000;
            endcase
      end
   end

   function automatic logic g_lim_oor(input int i);
      g_lim_oor = pv[i] > s_reg.lim[i].hi || pv[i] < s_reg.lim[i].lo;
   endfunction : g_lim_oor

   function automatic logic [`APIU_NSRC-1:0] latch_mask();
      for (int i = 0; i < `APIU_NSRC; i++)
         latch_mask[i] = s_reg.cfg[i].latch;
   endfunction : latch_mask

   function automatic logic [`APIU_NSRC-1:0] contact_mask();
      for (int i = 0; i < `APIU_NSRC; i++)
         contact_mask[i] = s_reg.cfg[i].contact;
   endfunction : contact_mask

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         s_reg <= '0;
      else
         s_reg <= s_next;

   // flash sequencer runs whenever a source is being shown
   assign fl.req_valid = s_reg.sel_sev != `APIU_SEV_OFF;
   assign fl.sev = s_reg.sel_sev;
   assign fl.code = s_reg.sel_code;

   apiu_flasher #(
      .HALF_CYC(FLASH_HALF_CYC)
   ) u_flash (
      .pclk(pclk),
      .presetn(presetn),
      .fl(fl)
   );

   // outputs; contact is open (high) with no alarm
   assign led_red = fl.led_red;
   assign led_green = fl.led_green;
   assign alarm_contact = !s_reg.contact_closed;
   assign alarm_to_outputs = s_reg.alarm_out;
   assign host_alarm = s_reg.host;
   assign irq = |(s_reg.irq_stat & s_reg.irq_mask);
   assign fixed_mode_primary = s_reg.fixed_pri;
   assign fixed_mode_secondary = s_reg.fixed_sec;
   assign fixed_value = s_reg.fixed_val;
   assign prdata = s_reg.prdata;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_off_silent;
      s_reg.ind[0] |-> $past(s_reg.cfg[0].sev) != `APIU_SEV_OFF;
   endproperty
   a_off_silent: assert property (p_off_silent)
      else $error("disabled source shows an indication");

   property p_alarm_out;
      |(s_reg.ind & $past(sev2)) |-> alarm_to_outputs;
   endproperty
   a_alarm_out: assert property (p_alarm_out)
      else $error("alarm source did not flag analog outputs");

   property p_contact;
      |(s_reg.ind & $past(cmask)) |-> !alarm_contact;
   endproperty
   a_contact: assert property (p_contact)
      else $error("contact not closed for active source");

   property p_latch_hold;
      s_reg.cfg[`APIU_SRC_SLUG].latch && s_reg.ind[`APIU_SRC_SLUG] &&
         !clr[`APIU_SRC_SLUG] && $stable(s_reg.cfg[`APIU_SRC_SLUG])
         |=> s_reg.ind[`APIU_SRC_SLUG];
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latched source dropped without clear");

   property p_prio;
      |(s_reg.ind & $past(sev2)) |-> s_reg.sel_sev == `APIU_SEV_ALARM;
   endproperty
   a_prio: assert property (p_prio)
      else $error("warning shown while an alarm is active");

   property p_trim_fix;
      s_reg.trim == apiu_pkg::APIU_TR_ASK && wr && paddr == `APIU_OFF_TRIM
         && pwdata[`APIU_TRIM_CONFIRM] && !pwdata[`APIU_TRIM_DECLINE]
         |=> (fixed_mode_primary || fixed_mode_secondary);
   endproperty
   a_trim_fix: assert property (p_trim_fix)
      else $error("confirmed trim did not enter fixed mode");

   property p_trim_decl;
      s_reg.trim == apiu_pkg::APIU_TR_ASK && wr && paddr == `APIU_OFF_TRIM
         && pwdata[`APIU_TRIM_DECLINE] |=> s_reg.trim == apiu_pkg::APIU_TR_IDLE
         && !fixed_mode_primary && !fixed_mode_secondary;
   endproperty
   a_trim_decl: assert property (p_trim_decl)
      else $error("declined trim did not abort");

   property p_readback;
      presetn |=> s_reg.readback == $past(primary_output_current);
   endproperty
   a_readback: assert property (p_readback)
      else $error("readback not refreshed");

   property p_host;
      host_alarm == s_reg.ind;
   endproperty
   a_host: assert property (p_host)
      else $error("host alarm bits lag the indication");

   c_alarm: cover property (alarm_to_outputs && !alarm_contact);
   c_trim: cover property (fixed_mode_primary ##[1:50] !fixed_mode_primary);
   c_latch: cover property (s_reg.latched != 6'h00 ##1 clr != 6'h00);
endmodule : apiu_alarm

// file: tb/apiu_operator.sv
`timescale 1ns/1ps
module apiu_operator (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // indicator as the operator sees it
   input wire logic led_red,
   input wire logic led_green,
   // flashes seen so far
   output logic [7:0] red_cnt,
   output logic [7:0] green_cnt
);
   logic red_q;
   logic green_q;

   // one flash is one rise; counts wrap, so users take differences
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         red_q <= 1'b0;
         green_q <= 1'b0;
         red_cnt <= 8'h00;
         green_cnt <= 8'h00;
      end
      else
      begin
         red_q <= led_red;
         green_q <= led_green;
         red_cnt <= red_cnt + 8'(led_red && !red_q);
         green_cnt <= green_cnt + 8'(led_green && !green_q);
      end
   end
endmodule : apiu_operator

// file: tb/alarm_priority_indicator_bench.sv
`timescale 1ns/1ps
`include "apiu_defines.svh"
module alarm_priority_indicator_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr, red_cnt, green_cnt, r0, g0;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] pv_m, pv_d, pv_v, pv_t, poc, fixed_value;
   logic diag_fail, sec_tick, led_red, led_green, alarm_contact;
   logic alarm_to_outputs, irq, fix_p, fix_s;
   logic [5:0] host_alarm;
   int err_count, checks;

   // alarm block with a four-cycle flash half period
   apiu_alarm #(.FLASH_HALF_CYC(4)) apiu_alarm_i (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .pv_mass_flow(pv_m), .pv_density(pv_d), .pv_vol_flow(pv_v),
      .pv_temperature(pv_t), .diag_fail, .sec_tick,
      .primary_output_current(poc), .led_red, .led_green, .alarm_contact,
      .alarm_to_outputs, .host_alarm, .irq, .fixed_mode_primary(fix_p),
      .fixed_mode_secondary(fix_s), .fixed_value);
   apiu_operator apiu_operator_i (.pclk, .presetn, .led_red, .led_green,
      .red_cnt, .green_cnt);

   // free running 100 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic results;
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] s);
      checks++;
      if (s !== x)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         err_count++;
         results();
      end
      else
      begin
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, x, q);
   endtask : rdc

   task automatic tick;
      sec_tick <= 1'b1;
      cyc(1);
      sec_tick <= 1'b0;
      cyc(4);
   endtask : tick

   // wait for the gap between sequences, then count one whole sequence
   task automatic flash(input logic [7:0] xr, input logic [7:0] xg,
                        input int w);
      int low, n;
      low = 0;
      n = 0;
      // leds are looked at mid-cycle, away from the edge that moves them
      while (low < 10 && n < 2000)
      begin
         @(negedge pclk);
         n++;
         low = (led_red || led_green) ? 0 : low + 1;
      end
      if (low < 10)
      begin
         err_count++;
         results();
      end
      r0 = red_cnt;
      g0 = green_cnt;
      cyc(w);
      chk("red_flashes", 32'(xr), 32'(red_cnt - r0));
      chk("green_flashes", 32'(xg), 32'(green_cnt - g0));
   endtask : flash

   // main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pv_m, pv_d, pv_v, pv_t, poc} = {5{16'h0100}};
      {diag_fail, sec_tick, presetn} = 3'h0;
      err_count = 0;
      checks = 0;
      cyc(12);
      presetn <= 1'b1;
      cyc(1);
      chk("contact_idle", 32'h1, 32'(alarm_contact));
      rdc("status_rst", `APIU_OFF_STATUS, 32'h0);
      apb(1'b0, 8'h60, 32'h0);
      chk("unmapped", 32'h1, 32'(e));
      for (int i = 0; i < 5; i++)
         wr(`APIU_OFF_LIM + 8'(4 * i), 32'h02000080);
      wr(`APIU_OFF_IRQ_MASK, 32'h1);
      pv_m <= 16'h0300;
      wr(`APIU_OFF_CFG, 32'h34);
      cyc(4);
      chk("off_src", 32'h0, 32'(host_alarm));
      chk("off_contact", 32'h1, 32'(alarm_contact));
      wr(`APIU_OFF_CFG, 32'h36);
      cyc(4);
      chk("alarm_host", 32'h1, 32'(host_alarm));
      chk("alarm_out", 32'h1, 32'(alarm_to_outputs));
      chk("contact_on", 32'h0, 32'(alarm_contact));
      chk("irq_on", 32'h1, 32'(irq));
      rdc("irq_stat", `APIU_OFF_IRQ_STAT, 32'h1);
      wr(`APIU_OFF_IRQ_MASK, 32'h0);
      chk("irq_masked", 32'h0, 32'(irq));
      wr(`APIU_OFF_IRQ_STAT, 32'h1);
      rdc("irq_clr", `APIU_OFF_IRQ_STAT, 32'h0);
      wr(`APIU_OFF_CFG + 8'h0C, 32'h91);
      wr(`APIU_OFF_CFG + 8'h08, 32'h32);
      wr(`APIU_OFF_CFG + 8'h14, 32'h11);
      {pv_t, pv_v, diag_fail} <= {16'h0010, 16'h0300, 1'b1};
      cyc(4);
      chk("several", 32'h2D, 32'(host_alarm));
      apb(1'b0, `APIU_OFF_STATUS, 32'h0);
      chk("shown_tie", 32'h0E, 32'(q[17:12]));
      diag_fail <= 1'b0;
      wr(`APIU_OFF_CFG + 8'h04, 32'h0252);
      pv_d <= 16'h0300;
      cyc(4);
      chk("delay_0", 32'h0, 32'(host_alarm[1]));
      tick();
      chk("delay_1", 32'h0, 32'(host_alarm[1]));
      tick();
      chk("delay_2", 32'h1, 32'(host_alarm[1]));
      apb(1'b0, `APIU_OFF_STATUS, 32'h0);
      chk("shown_top", 32'h16, 32'(q[17:12]));
      flash(8'h05, 8'h00, 60);
      wr(`APIU_OFF_CFG + 8'h10, 32'h19);
      cyc(4);
      pv_d <= 16'h0100;
      cyc(4);
      chk("latch_hold", 32'h1, 32'(host_alarm[4]));
      wr(`APIU_OFF_LATCH_CLR, 32'h10);
      cyc(4);
      chk("latch_clr", 32'h0, 32'(host_alarm[4]));
      pv_d <= 16'h0300;
      cyc(4);
      wr(`APIU_OFF_LATCH_CLR, 32'h10);
      cyc(4);
      chk("relatch", 32'h1, 32'(host_alarm[4]));
      pv_d <= 16'h0100;
      cyc(4);
      chk("relatch_hold", 32'h1, 32'(host_alarm[4]));
      for (int i = 0; i < 6; i++)
         if (i != 3)
            wr(`APIU_OFF_CFG + 8'(4 * i), 32'h0);
      cyc(4);
      chk("warn_only", 32'h08, 32'(host_alarm));
      chk("warn_out", 32'h0, 32'(alarm_to_outputs));
      chk("warn_contact", 32'h1, 32'(alarm_contact));
      flash(8'h00, 8'h09, 94);
      poc <= 16'h1234;
      cyc(2);
      rdc("readback", `APIU_OFF_READBACK, 32'h1234);
      wr(`APIU_OFF_TRIM, 32'h00640001);
      rdc("trim_ask", `APIU_OFF_TRIM, 32'h00640001);
      wr(`APIU_OFF_TRIM, 32'h8);
      apb(1'b0, `APIU_OFF_TRIM, 32'h0);
      chk("trim_abort", 32'h0, 32'(q[1:0]));
      chk("abort_fix", 32'h0, 32'(fix_p));
      wr(`APIU_OFF_TRIM, 32'h00640001);
      wr(`APIU_OFF_TRIM, 32'h4);
      chk("fix_pri", 32'h1, 32'(fix_p));
      chk("fix_sec", 32'h0, 32'(fix_s));
      // adjust twice before the reading is accepted
      for (int k = 0; k < 2; k++)
         wr(`APIU_OFF_TRIM, {16'(16'h0070 + k), 16'h0000});
      chk("fix_value", 32'h0071, 32'(fixed_value));
      wr(`APIU_OFF_TRIM, 32'h10);
      chk("trim_done", 32'h0, 32'(fix_p));
      wr(`APIU_OFF_TRIM, 32'h3);
      wr(`APIU_OFF_TRIM, 32'h4);
      chk("fix_sec_on", 32'h1, 32'(fix_s));
      wr(`APIU_OFF_TRIM, 32'h10);
      results();
   end
endmodule : alarm_priority_indicator_bench
